// ==== core/ckrb_pkg.sv ====
package ckrb_pkg;

    // ***************************************************************
    // register addresses (6-bit immediate register space)
    // ***************************************************************
    localparam logic [5:0] ADDR_LINE_DEBUG = 6'h15;
    localparam logic [5:0] ADDR_SCRATCH = 6'h16;
    localparam logic [5:0] ADDR_SWITCH_CTRL = 6'h19;
    localparam logic [5:0] ADDR_EVENT_ENABLE = 6'h1d;
    localparam logic [5:0] ADDR_EVENT_STATUS = 6'h20;
    localparam logic [5:0] ADDR_EVENT_LATCH = 6'h21;

    // offsets from a writable register's base
    localparam logic [5:0] OFS_SET = 6'h01;
    localparam logic [5:0] OFS_CLEAR = 6'h02;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int LINE_STATE_LSB = 0;
    localparam int CTRL_KIT_POWER = 0;
    localparam int CTRL_ID_GND = 1;
    localparam int CTRL_UART_TX = 2;
    localparam int CTRL_UART_RX = 3;
    localparam int CTRL_SPK_LEFT = 4;
    localparam int CTRL_SPK_RIGHT = 5;
    localparam int CTRL_MIC = 6;
    localparam int EN_OPEN_RISE = 0;
    localparam int EN_OPEN_FALL = 1;
    localparam int EN_CONV_IRQ = 5;
    localparam int STAT_ID_OPEN = 0;
    localparam int STAT_CODE_LSB = 3;
    localparam int STAT_CONV_DONE = 6;
    localparam int LATCH_ID_OPEN = 0;
    localparam int LATCH_CONV = 3;

    // ***************************************************************
    // implemented-bit masks and reset values
    // ***************************************************************
    localparam logic [7:0] MASK_SCRATCH = 8'hff;
    localparam logic [7:0] MASK_SWITCH_CTRL = 8'h7e;
    localparam logic [7:0] MASK_EVENT_ENABLE = 8'h23;
    localparam logic [7:0] RST_SCRATCH = 8'h00;
    localparam logic [7:0] RST_SWITCH_CTRL = 8'h00;
    localparam logic [7:0] RST_EVENT_ENABLE = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // ***************************************************************
    // resistor conversion codes and timing
    // ***************************************************************
    localparam logic [2:0] CODE_ZERO_OHM = 3'h0;
    localparam logic [2:0] CODE_ID_FLOATING = 3'h5;
    localparam logic [2:0] CODE_ERROR = 3'h7;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 282000;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;

    // register access request as decoded from the link's register command
    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } ckrb_reg_req_t;

    // analog switch and pad controls
    typedef struct packed {
        logic id_pin_ground_drive;
        logic uart_transmit_connect;
        logic uart_receive_connect;
        logic left_speaker_switch;
        logic right_speaker_switch;
        logic microphone_switch;
        logic uart_to_left_audio_pin;
        logic uart_to_right_or_mic_audio_pin;
        logic dm_to_left_audio_pin;
        logic dp_to_right_or_mic_audio_pin;
        logic single_ended_rx_disable;
        logic data1_hold_high;
    } ckrb_switch_t;

endpackage

// ==== core/ckrb_top.sv ====
// Summary of operation
// - debug register shows live two-bit line condition in bits 1:0, rest zero
// - eight-bit scratch byte, reset zero, read/write/set/clear, no side effects
// - writable registers: base writes, base+1 sets, base+2 clears, all read back
// - with uart receive connect clear, data line 1 is held high
// - control bit 1 drives the id pin to ground
// - control bit 2 joins data line 0, uart transmit, to dm
// - control bit 3 joins data line 1, uart receive, to dp
// - control bit 4 joins dm to the left audio pin
// - dp joins right/mic pin while bit 5 or 6 set; opens when both clear
// - uart plus audio switches together route uart data to audio pins
// - any speaker or microphone switch disables the single-ended receivers
// - kit power and unimplemented detect fields read zero, writes ignored
// - rise enable: id going open raises the alternate interrupt
// - fall enable: id leaving open raises the alternate interrupt
// - conversion interrupt enable is or'ed with its vendor duplicate
// - status bits 5:3 report the id resistor conversion code
// - status bit 6 sets at conversion end, cleared only by vendor read
// - latch bit 0 sets on an enabled id open/close change
// - latch bit 3 sets on enabled conversion-done rising edge
// - latch is read-only and reading it clears the latched bits

`timescale 1ns/1ps
`default_nettype none

module ckrb_top #(
    parameter int CONV_CYCLES = ckrb_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire ckrb_pkg::ckrb_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [1:0] line_state_i,
    input wire logic id_open_i,
    input wire logic conv_start_i,
    input wire logic [2:0] id_resistor_code_i,
    input wire logic vendor_conv_irq_enable_i,
    input wire logic vendor_conv_read_i,
    output logic conv_busy_o,
    output logic alt_int_o,
    input wire logic alt_int_ack_i,
    output ckrb_pkg::ckrb_switch_t switch_o
);

    // ***************************************************************
    // elaboration checks
    // ***************************************************************
    if (CONV_CYCLES < 1) begin : g_bad_conv
        $error("conversion cycle count must be at least one");
    end

    localparam int CNT_W = (CONV_CYCLES > 1) ? $clog2(CONV_CYCLES + 1) : 1;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // exact single-address match, used for every read-only register
    function automatic logic addr_is(input logic [5:0] a, input logic [5:0] b);
        addr_is = (a == b);
    endfunction

    // ***************************************************************
    // writable registers
    // ***************************************************************
    logic [7:0] scratch_q;
    logic [7:0] ctrl_q;
    logic [7:0] enable_q;
    logic scratch_hit;
    logic ctrl_hit;
    logic enable_hit;

    // scratch byte has no consumer apart from the read mux
    ckrb_wsc_reg #(
        .BASE(ckrb_pkg::ADDR_SCRATCH),
        .MASK(ckrb_pkg::MASK_SCRATCH),
        .RESET(ckrb_pkg::RST_SCRATCH)
    ) u_scratch (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .req_i(reg_req_i),
        .q_o(scratch_q),
        .hit_o(scratch_hit)
    );

    // kit power bit and bit 7 are masked off inside the register
    ckrb_wsc_reg #(
        .BASE(ckrb_pkg::ADDR_SWITCH_CTRL),
        .MASK(ckrb_pkg::MASK_SWITCH_CTRL),
        .RESET(ckrb_pkg::RST_SWITCH_CTRL)
    ) u_switch_ctrl (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .req_i(reg_req_i),
        .q_o(ctrl_q),
        .hit_o(ctrl_hit)
    );

    // detect and dp-event enables are not implemented and stay zero
    ckrb_wsc_reg #(
        .BASE(ckrb_pkg::ADDR_EVENT_ENABLE),
        .MASK(ckrb_pkg::MASK_EVENT_ENABLE),
        .RESET(ckrb_pkg::RST_EVENT_ENABLE)
    ) u_event_enable (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .req_i(reg_req_i),
        .q_o(enable_q),
        .hit_o(enable_hit)
    );

    // ***************************************************************
    // switch and pad control
    // ***************************************************************
    logic tx_con;
    logic rx_con;
    logic spk_l;
    logic spk_r;
    logic mic;
    logic dp_audio;

    assign tx_con = ctrl_q[ckrb_pkg::CTRL_UART_TX];
    assign rx_con = ctrl_q[ckrb_pkg::CTRL_UART_RX];
    assign spk_l = ctrl_q[ckrb_pkg::CTRL_SPK_LEFT];
    assign spk_r = ctrl_q[ckrb_pkg::CTRL_SPK_RIGHT];
    assign mic = ctrl_q[ckrb_pkg::CTRL_MIC];
    // either bit keeps the dp switch closed; both must drop to open it
    assign dp_audio = spk_r | mic;

    // outputs follow the control register directly, so a switch
    // changes one cycle after the write that requested it.
    // the link is trusted to keep uart and audio apart during audio use;
    // if it does not, the uart data simply appears on the audio pins.
    assign switch_o.id_pin_ground_drive = ctrl_q[ckrb_pkg::CTRL_ID_GND];
    assign switch_o.uart_transmit_connect = tx_con;
    assign switch_o.uart_receive_connect = rx_con;
    assign switch_o.left_speaker_switch = spk_l;
    assign switch_o.right_speaker_switch = spk_r;
    assign switch_o.microphone_switch = mic;
    assign switch_o.dm_to_left_audio_pin = spk_l;
    assign switch_o.dp_to_right_or_mic_audio_pin = dp_audio;
    assign switch_o.uart_to_left_audio_pin = tx_con & spk_l;
    assign switch_o.uart_to_right_or_mic_audio_pin = rx_con & dp_audio;
    assign switch_o.single_ended_rx_disable = spk_l | dp_audio;
    // keeps the receive line at idle level while the uart path is open
    assign switch_o.data1_hold_high = ~rx_con;

    // ***************************************************************
    // id pin open detection
    // ***************************************************************
    logic id_open_r;
    logic id_rise;
    logic id_fall;

    // pin is taken as synchronous; the register gives the previous level
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            id_open_r <= 1'b0;
        end else begin
            id_open_r <= id_open_i;
        end
    end

    assign id_rise = id_open_i & ~id_open_r;
    assign id_fall = ~id_open_i & id_open_r;

    // ***************************************************************
    // resistor conversion
    // ***************************************************************
    logic conv_busy_r;
    logic [CNT_W-1:0] conv_cnt_r;
    logic [2:0] conv_code_r;
    logic conv_done_r;
    logic conv_finish;
    logic conv_done_rise;
    logic conv_irq_en;

    assign conv_finish = conv_busy_r && (conv_cnt_r == CONV_LAST);

    // conversion timer; a start while busy is ignored so one run always
    // takes the full conversion time
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            conv_busy_r <= 1'b0;
            conv_cnt_r <= CNT_ZERO;
        end else if (conv_finish) begin
            conv_busy_r <= 1'b0;
            conv_cnt_r <= CNT_ZERO;
        end else if (conv_busy_r) begin
            conv_cnt_r <= conv_cnt_r + CNT_ONE;
        end else if (conv_start_i) begin
            conv_busy_r <= 1'b1;
            conv_cnt_r <= CNT_ZERO;
        end
    end

    // code is captured at the end of the run and held until the next
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            conv_code_r <= ckrb_pkg::CODE_ZERO_OHM;
        end else if (conv_finish) begin
            conv_code_r <= id_resistor_code_i;
        end
    end

    // done flag: a status read does not touch it; the vendor read clears
    // it, and a finish in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            conv_done_r <= 1'b0;
        end else if (conv_finish) begin
            conv_done_r <= 1'b1;
        end else if (vendor_conv_read_i) begin
            conv_done_r <= 1'b0;
        end
    end

    // done flag rising edge: it is low on the cycle the finish sets it
    assign conv_done_rise = conv_finish & ~conv_done_r;
    assign conv_irq_en = enable_q[ckrb_pkg::EN_CONV_IRQ] | vendor_conv_irq_enable_i;
    assign conv_busy_o = conv_busy_r;

    // ***************************************************************
    // event latch
    // ***************************************************************
    logic latch_id_r;
    logic latch_conv_r;
    logic latch_read;
    logic id_event;
    logic conv_event;

    assign latch_read = reg_req_i.rd && addr_is(reg_req_i.addr, ckrb_pkg::ADDR_EVENT_LATCH);
    assign id_event = (id_rise & enable_q[ckrb_pkg::EN_OPEN_RISE]) |
                      (id_fall & enable_q[ckrb_pkg::EN_OPEN_FALL]);
    assign conv_event = conv_done_rise & conv_irq_en;

    // a new event in the cycle of the read survives the clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            latch_id_r <= 1'b0;
        end else if (id_event) begin
            latch_id_r <= 1'b1;
        end else if (latch_read) begin
            latch_id_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            latch_conv_r <= 1'b0;
        end else if (conv_event) begin
            latch_conv_r <= 1'b1;
        end else if (latch_read) begin
            latch_conv_r <= 1'b0;
        end
    end

    // ***************************************************************
    // alternate interrupt toward the receive command byte
    // ***************************************************************
    logic alt_int_r;

    // held until the link's receive-command path reports it; a new event
    // beats the acknowledge so none is lost
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            alt_int_r <= 1'b0;
        end else if (id_event | conv_event) begin
            alt_int_r <= 1'b1;
        end else if (alt_int_ack_i) begin
            alt_int_r <= 1'b0;
        end
    end

    assign alt_int_o = alt_int_r;

    // ***************************************************************
    // read path
    // ***************************************************************
    logic [7:0] debug_val;
    logic [7:0] status_val;
    logic [7:0] latch_val;
    logic [7:0] rdata_nxt;

    // unimplemented fields are left at zero
    always_comb begin
        debug_val = ckrb_pkg::RST_ZERO;
        debug_val[ckrb_pkg::LINE_STATE_LSB +: 2] = line_state_i;
        status_val = ckrb_pkg::RST_ZERO;
        status_val[ckrb_pkg::STAT_ID_OPEN] = id_open_r;
        status_val[ckrb_pkg::STAT_CODE_LSB +: 3] = conv_code_r;
        status_val[ckrb_pkg::STAT_CONV_DONE] = conv_done_r;
        latch_val = ckrb_pkg::RST_ZERO;
        latch_val[ckrb_pkg::LATCH_ID_OPEN] = latch_id_r;
        latch_val[ckrb_pkg::LATCH_CONV] = latch_conv_r;
    end

    // address decode; unmapped addresses read zero
    always_comb begin
        if (addr_is(reg_req_i.addr, ckrb_pkg::ADDR_LINE_DEBUG)) begin
            rdata_nxt = debug_val;
        end else if (scratch_hit) begin
            rdata_nxt = scratch_q;
        end else if (ctrl_hit) begin
            rdata_nxt = ctrl_q;
        end else if (enable_hit) begin
            rdata_nxt = enable_q;
        end else if (addr_is(reg_req_i.addr, ckrb_pkg::ADDR_EVENT_STATUS)) begin
            rdata_nxt = status_val;
        end else if (addr_is(reg_req_i.addr, ckrb_pkg::ADDR_EVENT_LATCH)) begin
            rdata_nxt = latch_val;
        end else begin
            rdata_nxt = ckrb_pkg::RST_ZERO;
        end
    end

    // read data captured with the request, valid one cycle later;
    // the latch value returned is the one before its clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= ckrb_pkg::RST_ZERO;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                reg_rdata_o <= rdata_nxt;
            end
        end
    end

endmodule

`default_nettype wire

// ==== core/ckrb_wsc_reg.sv ====
`timescale 1ns/1ps
`default_nettype none

// write / set / clear register at base, base+1, base+2
module ckrb_wsc_reg #(
    parameter logic [5:0] BASE = 6'h00,
    parameter logic [7:0] MASK = 8'hff,
    parameter logic [7:0] RESET = 8'h00
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire ckrb_pkg::ckrb_reg_req_t req_i,
    output logic [7:0] q_o,
    output logic hit_o
);

    logic [7:0] val_r;
    logic [7:0] val_nxt;

    // any of the three addresses reads the register back
    assign hit_o = (req_i.addr == BASE) ||
                   (req_i.addr == BASE + ckrb_pkg::OFS_SET) ||
                   (req_i.addr == BASE + ckrb_pkg::OFS_CLEAR);

    // plain write, set ones, clear ones; unimplemented bits never move
    always_comb begin
        val_nxt = val_r;
        if (req_i.wr) begin
            if (req_i.addr == BASE) begin
                val_nxt = req_i.wdata;
            end else if (req_i.addr == BASE + ckrb_pkg::OFS_SET) begin
                val_nxt = val_r | req_i.wdata;
            end else if (req_i.addr == BASE + ckrb_pkg::OFS_CLEAR) begin
                val_nxt = val_r & ~req_i.wdata;
            end
        end
        val_nxt = val_nxt & MASK;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            val_r <= RESET & MASK;
        end else begin
            val_r <= val_nxt;
        end
    end

    assign q_o = val_r;

endmodule

`default_nettype wire

// ==== verification/ckrb_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module ckrb_bench;
    // ********
    // clock, reset and instances
    // ********
    localparam logic [5:0] A_DBG = ckrb_pkg::ADDR_LINE_DEBUG;
    localparam logic [5:0] A_SCR = ckrb_pkg::ADDR_SCRATCH;
    localparam logic [5:0] A_CTL = ckrb_pkg::ADDR_SWITCH_CTRL;
    localparam logic [5:0] A_EN = ckrb_pkg::ADDR_EVENT_ENABLE;
    localparam logic [5:0] A_ST = ckrb_pkg::ADDR_EVENT_STATUS;
    localparam logic [5:0] A_LAT = ckrb_pkg::ADDR_EVENT_LATCH;
    localparam logic [5:0] SET = ckrb_pkg::OFS_SET;
    localparam logic [5:0] CLR = ckrb_pkg::OFS_CLEAR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] line_state = 2'h0;
    logic id_open = 1'b0;
    logic conv_start = 1'b0;
    logic [2:0] code = 3'h0;
    logic vend_en = 1'b0;
    logic vend_rd = 1'b0;
    ckrb_pkg::ckrb_reg_req_t req;
    ckrb_pkg::ckrb_switch_t sw;
    logic [7:0] rdata;
    logic rvalid;
    logic busy;
    logic alt_int;
    logic ack;
    logic [7:0] rd_val;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    ckrb_top #(.CONV_CYCLES(8)) DUT (
        .clk_i(clk), .rst_n_i(rst_n), .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .line_state_i(line_state), .id_open_i(id_open), .conv_start_i(conv_start),
        .id_resistor_code_i(code), .vendor_conv_irq_enable_i(vend_en), .vendor_conv_read_i(vend_rd),
        .conv_busy_o(busy), .alt_int_o(alt_int), .alt_int_ack_i(ack), .switch_o(sw)
    );

    ckrb_link_model u_link (
        .clk_i(clk), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_req_o(req), .alt_int_ack_o(ack)
    );

    // ********
    // compare helpers
    // ********
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_sw(input ckrb_pkg::ckrb_switch_t got, input ckrb_pkg::ckrb_switch_t exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        u_link.read(a, rd_val);
        chk_byte(rd_val, exp);
    endtask

    // tx rides dm to left, rx rides dp to right/mic
    function automatic ckrb_pkg::ckrb_switch_t exp_sw(input logic [7:0] c);
        return '{c[1], c[2], c[3], c[4], c[5], c[6], c[2] & c[4], c[3] & (c[5] | c[6]),
                 c[4], c[5] | c[6], c[4] | c[5] | c[6], ~c[3]};
    endfunction

    // ********
    // scenarios
    // ********
    task automatic t_reset_values();
        chk_sw(sw, exp_sw(8'h00));
        rd_chk(A_SCR, 8'h00);
        rd_chk(A_CTL, 8'h00);
        rd_chk(A_EN, 8'h00);
        rd_chk(A_ST, 8'h00);
        rd_chk(A_LAT, 8'h00);
        rd_chk(6'h3f, 8'h00); // unmapped address reads zero
    endtask

    task automatic t_debug();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            line_state <= i[1:0];
            u_link.write(A_DBG, 8'hff); // read-only, must not stick
            rd_chk(A_DBG, {6'h00, i[1:0]});
        end
    endtask

    task automatic t_scratch();
        u_link.write(A_SCR, 8'ha5);
        rd_chk(A_SCR, 8'ha5);
        u_link.write(A_SCR + SET, 8'h5a);
        rd_chk(A_SCR + CLR, 8'hff);
        u_link.write(A_SCR + CLR, 8'h0f);
        rd_chk(A_SCR + SET, 8'hf0);
        chk_sw(sw, exp_sw(8'h00));
    endtask

    // mixed rows exercise pass-through
    task automatic t_switch();
        logic [7:0] tbl [12] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h60, 8'h14,
                                 8'h68, 8'h7e, 8'hff};
        for (int i = 0; i < 12; i++) begin
            u_link.write(A_CTL, tbl[i]);
            rd_chk(A_CTL, tbl[i] & 8'h7e);
            chk_sw(sw, exp_sw(tbl[i]));
        end
        u_link.write(A_CTL + CLR, 8'h0c);
        rd_chk(A_CTL, 8'h72);
        u_link.write(A_CTL + SET, 8'h08);
        rd_chk(A_CTL + CLR, 8'h7a);
        chk_sw(sw, exp_sw(8'h7a));
        u_link.write(A_CTL, 8'h00);
        u_link.write(A_EN, 8'hff);
        rd_chk(A_EN + SET, 8'h23);
        u_link.write(A_EN + CLR, 8'hff);
        rd_chk(A_EN, 8'h00);
        u_link.write(A_LAT, 8'hff);
        rd_chk(A_LAT, 8'h00);
    endtask

    task automatic id_step(input logic v, input logic [7:0] exp);
        @(posedge clk);
        id_open <= v;
        repeat (3) @(posedge clk);
        rd_chk(A_LAT, exp);
    endtask

    task automatic t_id_events();
        u_link.write(A_EN, 8'h01);
        id_step(1'b1, 8'h01);
        chk_byte(8'(alt_int), 8'h01);
        rd_chk(A_LAT, 8'h00);
        rd_chk(A_ST, 8'h01);
        u_link.ack();
        #1;
        chk_byte(8'(alt_int), 8'h00);
        id_step(1'b0, 8'h00);
        u_link.write(A_EN, 8'h02);
        id_step(1'b1, 8'h00);
        id_step(1'b0, 8'h01);
        chk_byte(8'(alt_int), 8'h01);
        u_link.ack();
        u_link.write(A_EN, 8'h00);
    endtask

    task automatic conv(input logic [2:0] c, input logic ven, input logic [7:0] exp_lat);
        @(posedge clk);
        code <= c;
        vend_en <= ven;
        conv_start <= 1'b1;
        @(posedge clk);
        conv_start <= 1'b0;
        #1;
        for (int i = 0; i < 30 && busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        repeat (2) @(posedge clk);
        rd_chk(A_ST, {2'b01, c, 3'h0});
        rd_chk(A_ST, {2'b01, c, 3'h0});
        rd_chk(A_LAT, exp_lat);
        chk_byte(8'(alt_int), 8'(exp_lat[3]));
        @(posedge clk);
        vend_rd <= 1'b1;
        @(posedge clk);
        vend_rd <= 1'b0;
        rd_chk(A_ST, {2'b00, c, 3'h0});
        u_link.ack();
    endtask

    task automatic t_conversion();
        for (int i = 0; i < 8; i++) begin
            conv(i[2:0], i[0], {4'h0, i[0], 3'h0});
        end
        u_link.write(A_EN, 8'h20);
        conv(ckrb_pkg::CODE_ID_FLOATING, 1'b0, 8'h08);
    endtask

    // ********
    // run control
    // ********
    task automatic complete_run();
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ceiling far above the ~370 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_debug();
        t_scratch();
        t_switch();
        t_id_events();
        t_conversion();
        complete_run();
    end
endmodule

`default_nettype wire

// ==== verification/ckrb_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ********
// link side register master
// ********
module ckrb_link_model (
    input wire logic clk_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output var ckrb_pkg::ckrb_reg_req_t reg_req_o,
    output var logic alt_int_ack_o
);
    initial begin
        reg_req_o = '0;
        alt_int_ack_o = 1'b0;
    end

    // commands go out in call order
    task automatic write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_req_o <= '{1'b0, 1'b1, a, d};
        @(posedge clk_i);
        reg_req_o <= '{1'b0, 1'b0, ~a, ~d}; // idle lines change
    endtask

    // rdata holds until the next read
    task automatic read(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_req_o <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk_i);
        reg_req_o <= '{1'b0, 1'b0, ~a, 8'hff};
        #1;
        if (reg_rvalid_i !== 1'b1) begin
            @(posedge clk_i);
            #1;
        end
        d = reg_rdata_i;
    endtask

    // alt interrupt sent upstream
    task automatic ack();
        @(posedge clk_i);
        alt_int_ack_o <= 1'b1;
        @(posedge clk_i);
        alt_int_ack_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== verification/ckrb_props.sv ====
`timescale 1ns/1ps
`default_nettype none

// ********
// port, routing, event checks
// ********
module ckrb_props #(
    parameter int CONV_CYCLES = ckrb_pkg::CONV_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire ckrb_pkg::ckrb_reg_req_t reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic [1:0] line_state_i,
    input wire logic conv_start_i,
    input wire logic conv_busy_o,
    input wire logic alt_int_o,
    input wire logic alt_int_ack_i,
    input wire ckrb_pkg::ckrb_switch_t switch_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    int busy_cnt_r;

    // busy run length
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !conv_busy_o) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1;
        end
    end

    a_read_gets_answer: assert property (reg_req_i.rd |=> reg_rvalid_o)
        else $error("no answer");
    a_answer_has_cause: assert property (reg_rvalid_o |-> $past(reg_req_i.rd))
        else $error("stray answer");
    a_debug_line_state: assert property (reg_req_i.rd && reg_req_i.addr == ckrb_pkg::ADDR_LINE_DEBUG
        |=> reg_rdata_o == {6'h00, $past(line_state_i)}) else $error("debug bad");
    a_rx_hold_high: assert property (switch_o.data1_hold_high != switch_o.uart_receive_connect)
        else $error("hold bad");
    a_dp_audio_join: assert property (switch_o.dp_to_right_or_mic_audio_pin ==
        (switch_o.right_speaker_switch | switch_o.microphone_switch)) else $error("dp join bad");
    a_se_rx_off: assert property (switch_o.single_ended_rx_disable == (switch_o.left_speaker_switch |
        switch_o.right_speaker_switch | switch_o.microphone_switch)) else $error("rx off bad");
    a_uart_audio_pass: assert property ((switch_o.uart_to_left_audio_pin ==
        (switch_o.uart_transmit_connect & switch_o.left_speaker_switch)) &&
        (switch_o.uart_to_right_or_mic_audio_pin == (switch_o.uart_receive_connect &
        (switch_o.right_speaker_switch | switch_o.microphone_switch)))) else $error("pass bad");
    a_ctrl_write_tx: assert property (reg_req_i.wr && reg_req_i.addr == ckrb_pkg::ADDR_SWITCH_CTRL
        |=> switch_o.uart_transmit_connect == $past(reg_req_i.wdata[2])) else $error("tx write lost");
    a_ctrl_set_gnd: assert property (reg_req_i.wr && reg_req_i.wdata[1] &&
        reg_req_i.addr == ckrb_pkg::ADDR_SWITCH_CTRL + ckrb_pkg::OFS_SET |=> switch_o.id_pin_ground_drive)
        else $error("set access failed");
    a_ctrl_clear_rx: assert property (reg_req_i.wr && reg_req_i.wdata[3] &&
        reg_req_i.addr == ckrb_pkg::ADDR_SWITCH_CTRL + ckrb_pkg::OFS_CLEAR |=> !switch_o.uart_receive_connect)
        else $error("clear access failed");
    a_alt_int_stands: assert property (alt_int_o && !alt_int_ack_i |=> alt_int_o)
        else $error("alt dropped");
    a_conv_starts: assert property (conv_start_i && !conv_busy_o |=> conv_busy_o)
        else $error("no start");
    a_conv_bounded: assert property (conv_busy_o |-> busy_cnt_r <= CONV_CYCLES)
        else $error("too long");

    c_alt_ack: cover property (alt_int_o && alt_int_ack_i);
    c_conv_end: cover property ($fell(conv_busy_o));
    c_read_data: cover property (reg_rvalid_o && reg_rdata_o != 8'h00);
endmodule

bind ckrb_top ckrb_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (.*);

`default_nettype wire
